//--- inc/msep_regs.svh
`ifndef MSEP_REGS_SVH
`define MSEP_REGS_SVH

// register addresses on the core's register bus
`define MSEP_POWER_CTRL_ADDR 8'h87
`define MSEP_AUX_CTRL_ADDR 8'h8E
`define MSEP_WDOG_CTRL_ADDR 8'h8F
`define MSEP_EXTIRQ_CTRL_ADDR 8'hC0
`define MSEP_NIBBLE_PORT_ADDR 8'hD8

// external interrupt control fields
`define MSEP_X3_PRIO_BIT 7
`define MSEP_X3_EN_BIT 6
`define MSEP_X3_PEND_BIT 5
`define MSEP_X3_EDGE_BIT 4
`define MSEP_X2_PRIO_BIT 3
`define MSEP_X2_EN_BIT 2
`define MSEP_X2_PEND_BIT 1
`define MSEP_X2_EDGE_BIT 0

// auxiliary control field
`define MSEP_ALE_SUPPRESS_BIT 0

// power control fields
`define MSEP_COLD_BOOT_BIT 4
`define MSEP_USER_FLAG1_BIT 3
`define MSEP_USER_FLAG0_BIT 2
`define MSEP_PDOWN_BIT 1
`define MSEP_SLEEP_BIT 0

// watchdog control fields
`define MSEP_WDOG_EN_BIT 7
`define MSEP_WDOG_RESTART_BIT 6
`define MSEP_WDOG_RUN_SLEEP_BIT 4
`define MSEP_WDOG_PS_HI 2
`define MSEP_WDOG_PS_LO 0

// reset values
`define MSEP_PORT_RST 4'hF
`define MSEP_REG_RST 8'h00

// interrupt vectors, index is the polling order
`define MSEP_VEC_EXT0 8'h03
`define MSEP_VEC_TMR0 8'h0B
`define MSEP_VEC_EXT1 8'h13
`define MSEP_VEC_TMR1 8'h1B
`define MSEP_VEC_SERIAL 8'h23
`define MSEP_VEC_EXT2 8'h33
`define MSEP_VEC_EXT3 8'h3B
`define MSEP_SRC_EXT2 3'h5
`define MSEP_SRC_EXT3 3'h6

// timing counts
`define MSEP_OSC_PER_MC 12
`define MSEP_WDOG_TIMER_BITS 14
`define MSEP_WDOG_HOLD_MC 2

`endif

//--- inc/msep_pkg.sv
`default_nettype none

package msep_pkg;

  // one register bus request from the core
  typedef struct packed {
    logic [7:0] addr;   // byte address, or bit address on bit_wr
    logic [7:0] wdata;
    logic wr;           // byte write
    logic rd;           // byte read
    logic rmw;          // read belongs to read-modify-write
    logic bit_wr;       // single bit write
    logic bit_val;
  } msep_sfr_req_t;

  // winning interrupt request toward the core
  typedef struct packed {
    logic req;
    logic high;
    logic [2:0] src;
    logic [7:0] vector;
  } msep_irq_t;

  // power state
  typedef enum logic [1:0] {
    MSEP_RUN,
    MSEP_IDLE,
    MSEP_PDOWN
  } msep_pwr_t;

endpackage : msep_pkg

`default_nettype wire

//--- hw/msep_extirq_chan.sv
`include "msep_regs.svh"
`default_nettype none

module msep_extirq_chan (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // synchronised pin level
  input wire logic pin_lvl,
  // control
  input wire logic edge_sel,
  input wire logic sw_wr,
  input wire logic sw_val,
  input wire logic service,
  // flag
  output logic pending
);

  logic pin_d_r;
  logic pending_r;
  logic fall;

  // previous level for edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_d_r <= 1'b1;
    end else begin
      pin_d_r <= pin_lvl;
    end
  end

  assign fall = pin_d_r & ~pin_lvl;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pending_r <= 1'b0;
    end else if (!edge_sel) begin
      pending_r <= ~pin_lvl;     // level mode tracks the pin
    end else if (fall) begin
      pending_r <= 1'b1;
    end else if (service) begin
      pending_r <= 1'b0;
    end else if (sw_wr) begin
      pending_r <= sw_val;
    end
  end

  assign pending = pending_r;

endmodule : msep_extirq_chan

`default_nettype wire

//--- hw/msep_periph.sv
`include "msep_regs.svh"
`default_nettype none

module msep_periph
  import msep_pkg::*;
#(
  parameter int OSC_PER_MC = `MSEP_OSC_PER_MC,
  parameter int TIMER_BITS = `MSEP_WDOG_TIMER_BITS,
  parameter int HOLD_MC = `MSEP_WDOG_HOLD_MC
) (
  // clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_on_rst,
  // register bus
  input wire msep_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // other interrupt sources and core answer
  input wire logic [4:0] src_req,
  input wire logic [4:0] src_high,
  output msep_irq_t irq,
  input wire logic irq_ack,
  input wire logic [2:0] irq_ack_src,
  // address latch strobe
  input wire logic core_ale,
  input wire logic ext_access,
  output logic ale_out,
  // nibble port pins
  input wire logic [3:0] nibble_port_in,
  output logic [3:0] nibble_port_out,
  output logic [3:0] nibble_port_oe_n,
  // power and reset outputs
  output logic core_sleep,
  output logic power_down,
  output logic wdog_rst
);

  localparam int HOLD_CLKS = OSC_PER_MC * HOLD_MC;
  localparam int MC_W = $clog2(OSC_PER_MC);
  localparam int HOLD_W = $clog2(HOLD_CLKS + 1);

  logic rst;
  logic [7:0] xctl_r;       // enables, priorities, edge selects
  logic x2_pend, x3_pend;
  logic ale_sup_r;
  logic cold_boot_r;
  logic [1:0] user_flag_r;
  msep_pwr_t pwr_r;
  logic wdog_en_r, wdog_restart_r, wdog_sleep_r;
  logic [2:0] wdog_ps_r;
  logic [3:0] port_latch_r;
  logic [3:0] pin_s1_r, pin_s2_r;
  logic [MC_W-1:0] mc_cnt_r;
  logic mc_tick;
  logic [7:0] pre_r;
  logic [7:0] pre_mask;
  logic pre_tick;
  logic [TIMER_BITS-1:0] timer_r;
  logic wdog_run;
  logic timeout;
  logic [HOLD_W-1:0] hold_r;
  logic wdog_rst_r;
  logic ale_r;
  logic [7:0] rdata_r;
  logic hit_r;
  msep_irq_t irq_r, irq_nxt;
  logic [6:0] all_req, all_high;
  logic [7:0] vec_tab [7];
  logic wr_xctl, wr_aux, wr_pwr, wr_wdog, wr_port;
  logic [7:0] xctl_new, aux_new, pwr_new, wdog_new, port_new;

  // any reset: power-on, system, or our own time-out reset
  // time-out resets the block, all but the cold boot flag and its own hold counter
  assign rst = sys_rst | power_on_rst | wdog_rst_r;

  // merge a byte write or a single bit write into old contents
  function automatic logic [7:0] merge_wr(input logic [7:0] old_v);
    logic [7:0] v;
    v = old_v;
    if (sfr_req.wr) begin
      v = sfr_req.wdata;
    end else begin
      v[sfr_req.addr[2:0]] = sfr_req.bit_val;
    end
    return v;
  endfunction : merge_wr

  // true when a write of either kind targets this address
  function automatic logic wr_to(input logic [7:0] a);
    return (sfr_req.wr && sfr_req.addr == a) ||
      (sfr_req.bit_wr && {sfr_req.addr[7:3], 3'h0} == a);
  endfunction : wr_to

  // write decode; a process, so the bus fields read inside the
  // helpers wake it up, which a continuous assignment would miss
  always_comb begin
    wr_xctl = wr_to(`MSEP_EXTIRQ_CTRL_ADDR);
    wr_aux = wr_to(`MSEP_AUX_CTRL_ADDR);
    wr_pwr = wr_to(`MSEP_POWER_CTRL_ADDR);
    wr_wdog = wr_to(`MSEP_WDOG_CTRL_ADDR);
    wr_port = wr_to(`MSEP_NIBBLE_PORT_ADDR);
    xctl_new = merge_wr({xctl_r[7:6], x3_pend, xctl_r[4:2],
      x2_pend, xctl_r[0]});
    aux_new = merge_wr({7'h00, ale_sup_r});
    pwr_new = merge_wr(8'h00);
    wdog_new = merge_wr(8'h00);
    port_new = merge_wr({4'h0, port_latch_r});
  end

  // two-stage synchroniser on port pins
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_r <= `MSEP_PORT_RST;
      pin_s2_r <= `MSEP_PORT_RST;
    end else begin
      pin_s1_r <= nibble_port_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_latch_r <= `MSEP_PORT_RST;
    end else if (wr_port) begin
      port_latch_r <= port_new[3:0];
    end
  end

  assign nibble_port_out = port_latch_r;
  assign nibble_port_oe_n = port_latch_r;   // drive only a low

  always_ff @(posedge clk) begin
    if (rst) begin
      xctl_r <= `MSEP_REG_RST;
    end else if (wr_xctl) begin
      xctl_r <= xctl_new;
    end
  end

  msep_extirq_chan u_chan_two (
    .clk(clk),
    .sys_rst(rst),
    .pin_lvl(pin_s2_r[2]),
    .edge_sel(xctl_r[`MSEP_X2_EDGE_BIT]),
    .sw_wr(wr_xctl),
    .sw_val(xctl_new[`MSEP_X2_PEND_BIT]),
    .service(irq_ack && irq_ack_src == `MSEP_SRC_EXT2),
    .pending(x2_pend)
  );

  msep_extirq_chan u_chan_three (
    .clk(clk),
    .sys_rst(rst),
    .pin_lvl(pin_s2_r[3]),
    .edge_sel(xctl_r[`MSEP_X3_EDGE_BIT]),
    .sw_wr(wr_xctl),
    .sw_val(xctl_new[`MSEP_X3_PEND_BIT]),
    .service(irq_ack && irq_ack_src == `MSEP_SRC_EXT3),
    .pending(x3_pend)
  );

  assign vec_tab[0] = `MSEP_VEC_EXT0;
  assign vec_tab[1] = `MSEP_VEC_TMR0;
  assign vec_tab[2] = `MSEP_VEC_EXT1;
  assign vec_tab[3] = `MSEP_VEC_TMR1;
  assign vec_tab[4] = `MSEP_VEC_SERIAL;
  assign vec_tab[5] = `MSEP_VEC_EXT2;
  assign vec_tab[6] = `MSEP_VEC_EXT3;

  assign all_req = {x3_pend & xctl_r[`MSEP_X3_EN_BIT],
    x2_pend & xctl_r[`MSEP_X2_EN_BIT], src_req};
  assign all_high = {xctl_r[`MSEP_X3_PRIO_BIT],
    xctl_r[`MSEP_X2_PRIO_BIT], src_high};

  // high level first, then lowest index
  always_comb begin
    irq_nxt = '0;
    for (int i = 6; i >= 0; i--) begin
      if (all_req[i] && !all_high[i] && !irq_nxt.high) begin
        irq_nxt.req = 1'b1;
        irq_nxt.src = 3'(i);
        irq_nxt.vector = vec_tab[i];
      end
    end
    for (int i = 6; i >= 0; i--) begin
      if (all_req[i] && all_high[i]) begin
        irq_nxt.req = 1'b1;
        irq_nxt.high = 1'b1;
        irq_nxt.src = 3'(i);
        irq_nxt.vector = vec_tab[i];
      end
    end
  end

  // registered winner toward the core
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_r <= '0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign irq = irq_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      ale_sup_r <= 1'b0;
    end else if (wr_aux) begin
      ale_sup_r <= aux_new[`MSEP_ALE_SUPPRESS_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ale_r <= 1'b0;
    end else begin
      ale_r <= core_ale & (~ale_sup_r | ext_access);
    end
  end

  assign ale_out = ale_r;

  always_ff @(posedge clk) begin
    if (power_on_rst) begin
      cold_boot_r <= 1'b1;
    end else if (wr_pwr) begin
      cold_boot_r <= pwr_new[`MSEP_COLD_BOOT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      user_flag_r <= 2'h0;
    end else if (wr_pwr) begin
      user_flag_r <= pwr_new[`MSEP_USER_FLAG1_BIT:`MSEP_USER_FLAG0_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_r <= MSEP_RUN;
    end else begin
      unique case (pwr_r)
        MSEP_RUN: begin
          if (wr_pwr && pwr_new[`MSEP_PDOWN_BIT]) begin
            pwr_r <= MSEP_PDOWN;
          end else if (wr_pwr && pwr_new[`MSEP_SLEEP_BIT]) begin
            pwr_r <= MSEP_IDLE;
          end
        end
        MSEP_IDLE: begin
          if (irq_nxt.req) begin
            pwr_r <= MSEP_RUN;
          end
        end
        MSEP_PDOWN: begin
          pwr_r <= MSEP_PDOWN;     // only a reset ends it
        end
        default: begin
          pwr_r <= MSEP_RUN;
        end
      endcase
    end
  end

  assign core_sleep = (pwr_r == MSEP_IDLE);
  assign power_down = (pwr_r == MSEP_PDOWN);

  always_ff @(posedge clk) begin
    if (rst) begin
      wdog_en_r <= 1'b0;
      wdog_sleep_r <= 1'b0;
      wdog_ps_r <= 3'h0;
    end else if (wr_wdog) begin
      wdog_en_r <= wdog_new[`MSEP_WDOG_EN_BIT];
      wdog_sleep_r <= wdog_new[`MSEP_WDOG_RUN_SLEEP_BIT];
      wdog_ps_r <= wdog_new[`MSEP_WDOG_PS_HI:`MSEP_WDOG_PS_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wdog_restart_r <= 1'b0;
    end else if (wr_wdog && wdog_new[`MSEP_WDOG_RESTART_BIT]) begin
      wdog_restart_r <= 1'b1;
    end else if (mc_tick) begin
      wdog_restart_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mc_cnt_r <= '0;
    end else if (mc_tick) begin
      mc_cnt_r <= '0;
    end else begin
      mc_cnt_r <= mc_cnt_r + 1'b1;
    end
  end

  assign mc_tick = (mc_cnt_r == MC_W'(OSC_PER_MC - 1));

  assign wdog_run = wdog_en_r && pwr_r != MSEP_PDOWN &&
    (pwr_r != MSEP_IDLE || wdog_sleep_r);

  assign pre_mask = 8'hFF >> (3'h7 - wdog_ps_r);
  assign pre_tick = wdog_run && mc_tick && (pre_r & pre_mask) == pre_mask;

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_r <= 8'h00;
    end else if (wdog_restart_r && mc_tick) begin
      pre_r <= 8'h00;
    end else if (wdog_run && mc_tick) begin
      pre_r <= pre_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_r <= '0;
    end else if (wdog_restart_r && mc_tick) begin
      timer_r <= '0;
    end else if (pre_tick) begin
      timer_r <= timer_r + 1'b1;
    end
  end

  assign timeout = pre_tick && (&timer_r) && !wdog_restart_r;

  always_ff @(posedge clk) begin
    if (power_on_rst) begin
      hold_r <= '0;
      wdog_rst_r <= 1'b0;
    end else if (timeout) begin
      hold_r <= HOLD_W'(HOLD_CLKS - 1);
      wdog_rst_r <= 1'b1;
    end else if (hold_r != '0) begin
      hold_r <= hold_r - 1'b1;
    end else begin
      wdog_rst_r <= 1'b0;
    end
  end

  assign wdog_rst = wdog_rst_r;

  // registered read data, zero for reserved bits
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
      hit_r <= 1'b0;
    end else if (sfr_req.rd) begin
      hit_r <= 1'b1;
      unique case (sfr_req.addr)
        `MSEP_EXTIRQ_CTRL_ADDR: begin
          rdata_r <= {xctl_r[7:6], x3_pend, xctl_r[4:2], x2_pend,
            xctl_r[0]};
        end
        `MSEP_AUX_CTRL_ADDR: begin
          rdata_r <= {7'h00, ale_sup_r};
        end
        `MSEP_POWER_CTRL_ADDR: begin
          rdata_r <= {3'h0, cold_boot_r, user_flag_r, power_down,
            core_sleep};
        end
        `MSEP_WDOG_CTRL_ADDR: begin
          rdata_r <= {wdog_en_r, wdog_restart_r, 1'b0, wdog_sleep_r,
            1'b0, wdog_ps_r};
        end
        `MSEP_NIBBLE_PORT_ADDR: begin
          // read-modify-write sees the latch, plain reads the pins
          rdata_r <= {4'h0, sfr_req.rmw ? port_latch_r : pin_s2_r};
        end
        default: begin
          rdata_r <= 8'h00;
          hit_r <= 1'b0;
        end
      endcase
    end else begin
      hit_r <= 1'b0;
    end
  end

  assign sfr_rdata = rdata_r;
  assign sfr_hit = hit_r;

endmodule : msep_periph

`default_nettype wire

//--- verif/msep_periph_checker.sv
`default_nettype none

module msep_periph_checker
  import msep_pkg::*;
#(
  parameter int OSC_PER_MC = 12,
  parameter int TIMER_BITS = 14,
  parameter int HOLD_MC = 2
) (
  // clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_on_rst,
  // register bus
  input wire msep_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  // interrupts
  input wire logic [4:0] src_req,
  input wire logic [4:0] src_high,
  input wire msep_irq_t irq,
  // strobe
  input wire logic core_ale,
  input wire logic ext_access,
  input wire logic ale_out,
  // port, power, watchdog
  input wire logic [3:0] nibble_port_out,
  input wire logic [3:0] nibble_port_oe_n,
  input wire logic power_down,
  input wire logic wdog_rst
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hold_r;
  // cycles the watchdog reset has stood
  always_ff @(posedge clk) begin
    hold_r <= (power_on_rst || !wdog_rst) ? 8'h00 : hold_r + 8'h01;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst || power_on_rst || wdog_rst);
  sequence port_wr_s;
    sfr_req.wr && sfr_req.addr == 8'hD8;
  endsequence
  sequence odd_rd_s;
    sfr_req.rd && !(sfr_req.addr inside {8'h87, 8'h8E, 8'h8F, 8'hC0, 8'hD8});
  endsequence
  port_latch_a: assert property (
    port_wr_s |=> nibble_port_out == $past(sfr_req.wdata[3:0])
      && nibble_port_oe_n == nibble_port_out) else $error("port latch");
  unmapped_read_a: assert property (
    odd_rd_s |=> !sfr_hit && sfr_rdata == 8'h00) else $error("unmapped");
  irq_vector_a: assert property (
    irq.req |-> irq.vector == 8'h03 + {2'h0, irq.src, 3'h0}
      + ((irq.src >= 3'h5) ? 8'h08 : 8'h00))
    else $error("vector");
  high_first_a: assert property (
    irq.req && !irq.high |-> $past(src_req & src_high) == 5'h00)
    else $error("priority");
  poll_order_a: assert property (
    irq.req && irq.src < 3'h5 |-> ($past(src_req) & ~($past(src_high)
      ^ {5{irq.high}}) & ((5'h01 << irq.src) - 5'h01)) == 5'h00)
    else $error("polling");
  ale_idle_a: assert property (
    !$past(core_ale) |-> !ale_out) else $error("strobe");
  ale_ext_a: assert property (
    $past(core_ale && ext_access && !sys_rst && !power_on_rst && !wdog_rst)
      |-> ale_out)
    else $error("ext strobe");
  pdown_hold_a: assert property (
    power_down |=> power_down) else $error("power-down left");
  wdog_hold_a: assert property (disable iff (power_on_rst)
    $fell(wdog_rst) |-> hold_r == 8'(OSC_PER_MC * HOLD_MC))
    else $error("reset length");
endmodule : msep_periph_checker

bind msep_periph msep_periph_checker #(.OSC_PER_MC(OSC_PER_MC),
  .TIMER_BITS(TIMER_BITS), .HOLD_MC(HOLD_MC)) u_msep_periph_checker (
  .clk, .sys_rst, .power_on_rst, .sfr_req, .sfr_rdata, .sfr_hit, .src_req,
  .src_high, .irq, .core_ale, .ext_access, .ale_out, .nibble_port_out,
  .nibble_port_oe_n, .power_down, .wdog_rst);

`default_nettype wire

//--- verif/msep_cpu.sv
`default_nettype none

module msep_cpu
  import msep_pkg::*;
(
  // clock
  input wire logic clk,
  // register bus
  output var msep_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  // service answer
  output logic irq_ack,
  output logic [2:0] irq_ack_src
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rdata_q;
  logic hit_q;
  // bus idle from time zero
  initial begin
    sfr_req = '0;
    irq_ack = 1'b0;
    irq_ack_src = 3'h0;
  end
  // one request, k: 1 write, 2 read, 4 bit write; d[0] marks rmw
  task automatic xfer(input logic [2:0] k, input logic [7:0] a, d);
    @(posedge clk);
    #1;
    sfr_req = '{a, d, k[0], k[1], k[1] & d[0], k[2], d[0]};
    @(posedge clk);
    #1;
    rdata_q = sfr_rdata;
    hit_q = sfr_hit;
    sfr_req = '0;
  endtask : xfer
  // service one source
  task automatic ack(input logic [2:0] s);
    @(posedge clk);
    #1;
    irq_ack = 1'b1;
    irq_ack_src = s;
    @(posedge clk);
    #1;
    irq_ack = 1'b0;
  endtask : ack
  task automatic kick(input logic [7:0] c);
    xfer(3'h1, 8'h8F, c | 8'h40);
  endtask : kick
endmodule : msep_cpu

`default_nettype wire

//--- verif/testbench.sv
`default_nettype none

module testbench
  import msep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OSC = 2;
  localparam int TB = 4;
  localparam int WD = OSC * (1 << TB) * 2;
  logic clk, sys_rst, power_on_rst, core_ale, ext_access, irq_ack, seen;
  logic sfr_hit, ale_out, core_sleep, power_down, wdog_rst;
  logic [4:0] src_req, src_high;
  logic [3:0] pin_lo, nibble_port_in, nibble_port_out, nibble_port_oe_n;
  logic [7:0] sfr_rdata;
  logic [2:0] irq_ack_src;
  msep_sfr_req_t sfr_req;
  msep_irq_t irq;
  int bad_count, samples_checked, n;
  // pull-ups where the latch releases a pin
  assign nibble_port_in = nibble_port_oe_n & ~pin_lo;
  msep_periph #(.OSC_PER_MC(OSC), .TIMER_BITS(TB), .HOLD_MC(2)) u_msep_periph (
    .clk, .sys_rst, .power_on_rst, .sfr_req, .sfr_rdata, .sfr_hit, .src_req,
    .src_high, .irq, .irq_ack, .irq_ack_src, .core_ale, .ext_access,
    .ale_out, .nibble_port_in, .nibble_port_out, .nibble_port_oe_n,
    .core_sleep, .power_down, .wdog_rst);
  msep_cpu u_msep_cpu (.clk, .sfr_req, .sfr_rdata, .sfr_hit, .irq_ack,
    .irq_ack_src);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // remember any watchdog reset
  always @(posedge clk) if (wdog_rst) seen <= 1'b1;
  task automatic chk(input string s, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : wt
  task automatic wr(input logic [7:0] a, d);
    u_msep_cpu.xfer(3'h1, a, d);
  endtask : wr
  task automatic rdc(input string s, input logic [7:0] a, e);
    u_msep_cpu.xfer(3'h2, a, 8'h00);
    chk(s, e, u_msep_cpu.rdata_q);
  endtask : rdc
  task automatic rst();
    sys_rst = 1'b1;
    wt(2);
    sys_rst = 1'b0;
  endtask : rst
  // time-out length and reset length for one setting
  task automatic wdt(input logic [7:0] c, input int e);
    wr(8'h8F, c);
    n = 0;
    while (!wdog_rst && n < 4 * e) begin
      wt(1);
      n++;
    end
    chk("period", 8'h01, 8'(n > e - 4 && n < e + 4));
    n = 0;
    while (wdog_rst && n < 99) begin
      wt(1);
      n++;
    end
    chk("hold", 8'(OSC * 2), 8'(n));
    rdc("wd cleared", 8'h8F, 8'h00);
    rst();
  endtask : wdt
  task automatic t_regs();
    rdc("power_control", 8'h87, 8'h10);
    rdc("extirq_ctrl_reg", 8'hC0, 8'h00);
    rdc("aux", 8'h8E, 8'h00);
    chk("hit on", 8'h01, 8'(u_msep_cpu.hit_q));
    chk("oe", 8'h0F, 8'(nibble_port_oe_n));
    rdc("unmapped", 8'h90, 8'h00);
    chk("hit", 8'h00, 8'(u_msep_cpu.hit_q));
    wr(8'hD8, 8'h0A);
    chk("latch", 8'h0A, 8'(nibble_port_oe_n));
    pin_lo = 4'h2;
    wt(3);
    rdc("pins", 8'hD8, 8'h08);
    u_msep_cpu.xfer(3'h2, 8'hD8, 8'h01);
    chk("rmw", 8'h0A, u_msep_cpu.rdata_q);
    u_msep_cpu.xfer(3'h4, 8'hD8, 8'h01);
    chk("bit", 8'h0B, 8'(nibble_port_out));
    pin_lo = 4'h0;
    wr(8'hD8, 8'h0F);
    $display("register test done");
  endtask : t_regs
  task automatic t_irq();
    for (int i = 0; i < 5; i++) begin
      src_req = 5'h1F << i;
      wt(2);
      chk("vec", 8'(3 + 8 * i), irq.vector);
    end
    src_req = 5'h00;
    wr(8'hC0, 8'h10);
    pin_lo = 4'h8;
    wt(6);
    chk("masked", 8'h00, 8'(irq.req));
    rdc("pend", 8'hC0, 8'h30);
    u_msep_cpu.xfer(3'h4, 8'hC6, 8'h01);
    wt(1);
    chk("vec3", 8'h3B, irq.vector);
    u_msep_cpu.ack(3'h6);
    rdc("serviced", 8'hC0, 8'h50);
    pin_lo = 4'h0;
    wr(8'hC0, 8'h0C);
    pin_lo = 4'h4;
    src_req = 5'h01;
    wt(5);
    chk("vec2", 8'h33, irq.vector);
    rdc("level", 8'hC0, 8'h0E);
    src_high = 5'h01;
    wt(2);
    chk("pick0", 8'h03, irq.vector);
    {src_req, src_high} = '0;
    wr(8'hC0, 8'h44);
    pin_lo = 4'hC;
    wt(5);
    chk("pick2", 8'h33, irq.vector);
    pin_lo = 4'h0;
    wr(8'hC0, 8'h00);
    $display("interrupt test done");
  endtask : t_irq
  task automatic t_ale();
    wr(8'h8E, 8'h01);
    core_ale = 1'b1;
    wt(2);
    chk("ale off", 8'h00, 8'(ale_out));
    ext_access = 1'b1;
    wt(2);
    chk("ale ext", 8'h01, 8'(ale_out));
    ext_access = 1'b0;
    wt(2);
    chk("ale again", 8'h00, 8'(ale_out));
    wr(8'h8E, 8'h00);
    wt(1);
    chk("ale on", 8'h01, 8'(ale_out));
    core_ale = 1'b0;
    $display("strobe test done");
  endtask : t_ale
  task automatic t_power();
    wr(8'h87, 8'h1C);
    rdc("flags", 8'h87, 8'h1C);
    wr(8'h87, 8'h01);
    wt(1);
    chk("idle", 8'h01, 8'(core_sleep));
    src_req = 5'h02;
    wt(3);
    chk("wake", 8'h00, 8'(core_sleep));
    src_req = 5'h00;
    wr(8'h87, 8'h02);
    wt(1);
    chk("pdown", 8'h01, 8'(power_down));
    rst();
    chk("pd exit", 8'h00, 8'(power_down));
    rdc("warm", 8'h87, 8'h00);
    $display("power test done");
  endtask : t_power
  task automatic t_wdog();
    wdt(8'h80, WD);
    rdc("wd off", 8'h8F, 8'h00);
    wdt(8'h83, WD * 8);
    seen = 1'b0;
    wr(8'h8F, 8'h80);
    repeat (4) begin
      wt(WD / 2);
      u_msep_cpu.kick(8'h80);
    end
    wt(2);
    rdc("restart", 8'h8F, 8'h80);
    chk("kicked", 8'h00, 8'(seen));
    wr(8'h87, 8'h01);
    wt(WD * 2);
    chk("idle stop", 8'h00, 8'(seen));
    rst();
    wr(8'h8F, 8'h90);
    wr(8'h87, 8'h01);
    wt(WD * 2);
    chk("idle run", 8'h01, 8'(seen));
    $display("watchdog test done");
  endtask : t_wdog
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    {sys_rst, power_on_rst} = 2'b11;
    {core_ale, ext_access, seen} = '0;
    {src_req, src_high, pin_lo} = '0;
    bad_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    #1;
    {sys_rst, power_on_rst} = 2'b00;
    t_regs();
    t_irq();
    t_ale();
    t_power();
    t_wdog();
    tally_and_finish();
  end
  // cut a hang short
  initial begin
    #(8 * 20000);
    bad_count++;
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
